// ==== verilog/supply_drop_regs.vh ====
`ifndef SUPPLY_DROP_REGS_VH
`define SUPPLY_DROP_REGS_VH

// Special function register addresses
`define LVD_CTRL_ADDR       16'hffbe
`define THR_SEL_ADDR        16'hffbf
`define ADDR_W              16

// Control register fields
`define CTRL_ENABLE_BIT     7
`define CTRL_LEGACY_BIT     4
`define CTRL_ACTION_BIT     1
`define CTRL_FLAG_BIT       0
`define CTRL_RESET_VAL      8'h00
`define CTRL_WRITE_MASK     8'h82

// Read port values
`define RDATA_RESET_VAL     8'h00
`define UNMAPPED_READ_VAL   8'h00

// Threshold select register
`define THR_FIELD_MSB       3
`define THR_RESET_VAL       8'h00
`define THR_WRITE_MASK      8'h0f

// Reset cause register fields
`define CAUSE_LVD_BIT       0
`define CAUSE_CLKMON_BIT    1
`define CAUSE_WATCHDOG_BIT  4
`define CAUSE_RESET_VAL     8'h00

// Comparator settling time, software wait
`define SETTLE_TIME_US      200
`define CLK_MHZ             100

// Synchroniser depth
`define SYNC_STAGES         2

`endif

// ==== verilog/level_sync.v ====
`timescale 1ns/10ps
module level_sync #(
  parameter STAGES = 2
) (
  input  wire sys_clk_i,
  input  wire rst_n_i,
  input  wire async_i,
  output wire sync_o
);
  reg [STAGES-1:0] chain_q;

  // Only the final stage is visible outside
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_q <= {STAGES{1'b0}};
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_i};
    end
  end

  assign sync_o = chain_q[STAGES-1];
endmodule

// ==== verilog/low_voltage_detect_control.v ====
`timescale 1ns/10ps
`include "supply_drop_regs.vh"
module low_voltage_detect_control #(
  parameter LEGACY_BIT4_VAL = 1'b0
) (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire        por_n_i,
  input  wire        other_reset_i,
  input  wire        watchdog_reset_i,
  input  wire        clkmon_reset_i,
  input  wire        stop_mode_i,
  input  wire        cmp_below_i,
  input  wire [15:0] addr_i,
  input  wire        wr_i,
  input  wire        bit_wr_i,
  input  wire [2:0]  bit_sel_i,
  input  wire [7:0]  wdata_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  output wire        cmp_enable_o,
  output wire [3:0]  threshold_sel_o,
  output wire        supply_drop_irq_o,
  output wire        supply_drop_reset_o,
  output wire [7:0]  reset_cause_register_o
);
  reg        enable_q;
  reg        enable_d;
  reg        action_q;
  reg        action_d;
  reg  [7:0] thr_q;
  reg  [7:0] thr_d;
  reg  [7:0] cause_q;
  reg  [7:0] cause_d;
  reg  [7:0] rdata_d;
  reg  [7:0] ctrl_view;

  wire [7:0] ctrl_merged;
  wire       below_sync;
  wire       below_threshold_flag;
  wire       drop_reset;
  wire       ctrl_sel;
  wire       thr_sel;
  wire       ctrl_wr;
  wire       thr_wr;
  wire       clear_ctrl;

  // Merges a single-bit write into a byte with a writable-bit mask
  function [7:0] merge_wr;
    input [7:0] old;
    input [7:0] data;
    input       is_bit;
    input [2:0] sel;
    input [7:0] mask;
    reg   [7:0] nv;
    begin
      nv = old;
      if (is_bit) begin
        nv[sel] = data[0];
      end else begin
        nv = data;
      end
      merge_wr = (nv & mask) | (old & ~mask);
    end
  endfunction

  // Register select decode, shared by the write and read paths
  function reg_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      reg_hit = (addr == target);
    end
  endfunction

  // Analog output is asynchronous; sample it twice before any use
  level_sync #(
    .STAGES (`SYNC_STAGES)
  ) u_cmp_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (cmp_below_i),
    .sync_o    (below_sync)
  );

  // Stop mode does not gate the comparator path
  assign cmp_enable_o         = enable_q;
  assign threshold_sel_o      = thr_q[`THR_FIELD_MSB:0];
  assign below_threshold_flag = enable_q & below_sync;
  assign supply_drop_irq_o    = below_threshold_flag & ~action_q;
  assign drop_reset           = below_threshold_flag & action_q;
  assign supply_drop_reset_o  = drop_reset;
  // Reset request is a level; the chip reset logic decides how long it lasts
  // Stop mode input is left unread: stop mode must never gate detection

  assign ctrl_sel   = reg_hit(addr_i, `LVD_CTRL_ADDR);
  assign thr_sel    = reg_hit(addr_i, `THR_SEL_ADDR);
  assign ctrl_wr    = (wr_i | bit_wr_i) & ctrl_sel;
  // Threshold register takes byte writes only; a bit write there is dropped
  assign thr_wr     = wr_i & thr_sel;
  // Watchdog and clock monitor resets count as non-detector resets
  assign clear_ctrl = other_reset_i | watchdog_reset_i | clkmon_reset_i;

  // Bit or byte access merged onto the current view; flag and bit 4 masked off
  assign ctrl_merged = merge_wr(ctrl_view, wdata_i, bit_wr_i, bit_sel_i,
                                `CTRL_WRITE_MASK);

  // A reset source clears the mode bits even if software writes in that cycle
  always @* begin
    enable_d = enable_q;
    action_d = action_q;
    if (clear_ctrl) begin
      enable_d = 1'b0;
      action_d = 1'b0;
    end else if (ctrl_wr) begin
      enable_d = ctrl_merged[`CTRL_ENABLE_BIT];
      action_d = ctrl_merged[`CTRL_ACTION_BIT];
    end
  end

  // Detector's own reset must not wipe enable/action, so those bits sit
  // outside rst_n_i and are cleared by the other reset sources instead.
  always @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      enable_q <= 1'b0;
      action_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      action_q <= action_d;
    end
  end

  // Threshold register is byte-only; upper bits forced to zero
  always @* begin
    thr_d = thr_q;
    if (thr_wr) begin
      thr_d = wdata_i & `THR_WRITE_MASK;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thr_q <= `THR_RESET_VAL;
    end else begin
      thr_q <= thr_d;
    end
  end

  // Reset cause flags survive every reset except power-on-clear
  // Several sources may fire together; each sets only its own bit
  always @* begin
    cause_d = cause_q;
    if (drop_reset) begin
      cause_d[`CAUSE_LVD_BIT] = 1'b1;
    end
    if (watchdog_reset_i) begin
      cause_d[`CAUSE_WATCHDOG_BIT] = 1'b1;
    end
    if (clkmon_reset_i) begin
      cause_d[`CAUSE_CLKMON_BIT] = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      cause_q <= `CAUSE_RESET_VAL;
    end else begin
      cause_q <= cause_d;
    end
  end

  assign reset_cause_register_o = cause_q;

  // Bit 4 value is a parameter; software must not depend on it
  always @* begin
    ctrl_view                   = `CTRL_RESET_VAL;
    ctrl_view[`CTRL_ENABLE_BIT] = enable_q;
    ctrl_view[`CTRL_LEGACY_BIT] = LEGACY_BIT4_VAL[0];
    ctrl_view[`CTRL_ACTION_BIT] = action_q;
    ctrl_view[`CTRL_FLAG_BIT]   = below_threshold_flag;
  end

  // Read data holds between strobes
  // Unmapped addresses read as zero
  always @* begin
    rdata_d = rdata_o;
    if (rd_i) begin
      if (ctrl_sel) begin
        rdata_d = ctrl_view;
      end else if (thr_sel) begin
        rdata_d = thr_q;
      end else begin
        rdata_d = `UNMAPPED_READ_VAL;
      end
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `RDATA_RESET_VAL;
    end else begin
      rdata_o <= rdata_d;
    end
  end
endmodule

// ==== dv/lvd_monitor.sv ====
`timescale 1ns/10ps
module lvd_monitor (
  input wire       sys_clk_i,
  input wire       rst_n_i,
  input wire       por_n_i,
  input wire       watchdog_reset_i,
  input wire       clkmon_reset_i,
  input wire       cmp_below_i,
  input wire       cmp_enable_o,
  input wire       supply_drop_irq_o,
  input wire       supply_drop_reset_o,
  input wire [7:0] reset_cause_register_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !por_n_i);
  // Four cycles cover the two-stage synchroniser; the flag after it is not registered
  sequence low4; (!cmp_below_i) [*4]; endsequence
  sequence high4; (cmp_below_i && cmp_enable_o) [*4]; endsequence
  irq_mode_gate_a: assert property (supply_drop_irq_o |-> cmp_enable_o && !supply_drop_reset_o)
    else $error("irq without enable or with reset mode");
  drop_signals_a: assert property (high4 |-> supply_drop_irq_o || supply_drop_reset_o)
    else $error("no irq or reset while below");
  quiet_above_a: assert property (low4 |-> !supply_drop_irq_o && !supply_drop_reset_o)
    else $error("event while above threshold");
  quiet_off_a: assert property ((!cmp_enable_o) [*2] |-> !supply_drop_irq_o && !supply_drop_reset_o)
    else $error("event while disabled");
  cause_set_a: assert property (supply_drop_reset_o |-> ##[0:2] reset_cause_register_o[0])
    else $error("detector cause flag not set");
  cause_keep_a: assert property (($past(reset_cause_register_o) & ~reset_cause_register_o) == 8'h00)
    else $error("cause flag cleared");
  watchdog_cause_a: assert property (watchdog_reset_i |=> reset_cause_register_o[4] && !cmp_enable_o)
    else $error("watchdog cause wrong");
  clkmon_cause_a: assert property (clkmon_reset_i |=> reset_cause_register_o[1] && !cmp_enable_o)
    else $error("clock monitor cause wrong");
endmodule
bind low_voltage_detect_control lvd_monitor u_mon (.sys_clk_i, .rst_n_i, .por_n_i, .watchdog_reset_i,
  .clkmon_reset_i, .cmp_below_i, .cmp_enable_o, .supply_drop_irq_o, .supply_drop_reset_o,
  .reset_cause_register_o);

// ==== dv/tb_low_voltage_detect_control.sv ====
`timescale 1ns/10ps
`include "supply_drop_regs.vh"
module tb_low_voltage_detect_control;
  localparam logic [15:0] C = `LVD_CTRL_ADDR;
  logic        clk = 0, rst_n = 0, por_n = 0, oth = 0, wdog = 0, cm = 0, below = 0;
  logic        stp = 1, irq_mask = 0;
  logic        wr = 0, bws = 0, rd = 0, rd_q = 0, en, irq, lrst;
  logic [15:0] addr = 0;
  logic [2:0]  sel = 0;
  logic [7:0]  wd = 0, rdata, cause, q[$];
  logic [3:0]  thr, t;
  int          fail_count = 0, checked = 0, cyc = 0;
  always #5 clk = ~clk;
  low_voltage_detect_control u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n),
    .other_reset_i(oth), .watchdog_reset_i(wdog), .clkmon_reset_i(cm), .stop_mode_i(stp),
    .cmp_below_i(below), .addr_i(addr), .wr_i(wr), .bit_wr_i(bws), .bit_sel_i(sel),
    .wdata_i(wd), .rd_i(rd), .rdata_o(rdata), .cmp_enable_o(en), .threshold_sel_o(thr),
    .supply_drop_irq_o(irq), .supply_drop_reset_o(lrst), .reset_cause_register_o(cause));
  task automatic ck(logic [10:0] g, logic [10:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic go(logic [15:0] a, logic [7:0] d, logic w, logic b, logic r, logic [2:0] s);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = w;
    bws = b;
    rd = r;
    sel = s;
    @(negedge clk);
    wr = 0;
    bws = 0;
    rd = 0;
  endtask
  task automatic rd8(logic [15:0] a, logic [7:0] e);
    q.push_back(e);
    go(a, 8'h00, 0, 0, 1, 3'd0);
  endtask
  // Read data lands one cycle after the strobe edge
  always @(posedge clk) rd_q <= rd;
  // Bit 4 may read either way, so it is left out of every read compare
  always @(negedge clk) if (rd_q)
    ck({3'b000, rdata & 8'hef}, {3'b000, q.pop_front() & 8'hef});
  always @(posedge clk) begin
    cyc++;
    if (cyc > `SETTLE_TIME_US * `CLK_MHZ + 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h68f6));
    repeat (20) @(negedge clk);
    rst_n = 1;
    por_n = 1;
    rd8(C, 8'h00);
    irq_mask = 1;
    go(C, 8'hff, 1, 0, 0, 3'd0);
    rd8(C, 8'h82);
    t = 4'($urandom % 10);
    go(`THR_SEL_ADDR, {4'h0, t}, 1, 0, 0, 3'd0);
    ck({7'h0, thr}, {7'h0, t});
    rd8(`THR_SEL_ADDR, {4'h0, t});
    go(C, 8'h00, 0, 1, 0, 3'd1);
    repeat (`SETTLE_TIME_US * `CLK_MHZ) @(negedge clk);
    ck({9'h000, irq_mask, irq}, 11'h002);
    irq_mask = 0;
    below = 1;
    repeat (4) @(negedge clk);
    ck({en, irq, lrst, cause}, 11'h600);
    rd8(C, 8'h81);
    go(C, 8'h01, 0, 1, 0, 3'd1);
    repeat (3) @(negedge clk);
    ck({en, irq, lrst, cause}, 11'h501);
    // Detector reset routed to the chip reset keeps enable and action
    @(negedge clk) rst_n = 0;
    @(negedge clk) rst_n = 1;
    stp = 0;
    repeat (4) @(negedge clk);
    rd8(C, 8'h83);
    below = 0;
    go(C, 8'h00, 0, 1, 0, 3'd7);
    repeat (4) @(negedge clk);
    rd8(C, 8'h02);
    ck({en, irq, lrst, cause}, 11'h001);
    @(negedge clk) wdog = 1;
    @(negedge clk) wdog = 0;
    ck({en, irq, lrst, cause}, 11'h011);
    rd8(C, 8'h00);
    @(negedge clk) cm = 1;
    @(negedge clk) cm = 0;
    ck({en, irq, lrst, cause}, 11'h013);
    go(C, 8'h82, 1, 0, 0, 3'd0);
    @(negedge clk) oth = 1;
    @(negedge clk) oth = 0;
    rd8(C, 8'h00);
    rd8(16'h0000, 8'h00);
    @(negedge clk) por_n = 0;
    @(negedge clk) por_n = 1;
    ck({en, irq, lrst, cause}, 11'h000);
    repeat (2) @(negedge clk);
    results();
  end
endmodule
